// File: design/line_perf_meters_and_coef_access.sv
// Operation
// - signed receive input summed, upper half shown
// - snapshot every meter at interval end
// - meter pairs read low then high
// - absolute receive input summed, upper half
// - absolute post-cancel signal summed, upper half
// - count symbols with error above threshold
// - scrambler mode: count matching bits
// - descrambler mode: count output ones
// - count inner symbols, show top byte
// - absolute slicer error summed, upper half
// - loop integrator bits 30:15 read/write
// - integrator low byte held until high
// - fetch index loads coefficient into window
// - store index writes window into coefficient
module line_perf_meters_and_coef_access (
    input wire logic clk,
    input wire logic rst,
    input wire logic symStrobe,
    input wire logic intervalEnd,
    input wire logic [15:0] rxInput,
    input wire logic [15:0] rxFarEnd,
    input wire logic [15:0] slicerErr,
    input wire logic [15:0] noiseThreshold,
    input wire logic [1:0] symbolCode,
    input wire logic descramblerMode,
    input wire logic detBit,
    input wire logic scrBit,
    input wire logic loopStep,
    input wire logic [30:0] loopNext,
    output logic [30:0] loopAcc,
    input wire logic cs,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // ---------------------------------------------------------------
    // meter inputs
    // ---------------------------------------------------------------
    logic [31:0] dcSnap;
    logic [31:0] inMagSnap;
    logic [31:0] remMagSnap;
    logic [31:0] slcSnap;
    logic [15:0] hiErrSnap;
    logic [15:0] goodSnap;
    logic [15:0] innerSnap;
    logic [15:0] absIn;
    logic [15:0] absFar;
    logic [15:0] absErr;
    logic goodBit;
    logic innerSym;

    always_comb begin
        absIn = rxInput[15] ? 16'(-rxInput) : rxInput;
        absFar = rxFarEnd[15] ? 16'(-rxFarEnd) : rxFarEnd;
        absErr = slicerErr[15] ? 16'(-slicerErr) : slicerErr;
        goodBit = descramblerMode ? scrBit : (detBit == scrBit);
        // symbol code 2'b01 and 2'b10 stand for plus and minus one
        innerSym = symbolCode == 2'b01 || symbolCode == 2'b10;
    end

    lpm_accum #(.W(32)) uDc (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd), .addEn(symStrobe),
        .addVal({{16{rxInput[15]}}, rxInput}), .snap(dcSnap)
    );
    lpm_accum #(.W(32)) uInMag (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd), .addEn(symStrobe),
        .addVal({16'h0000, absIn}), .snap(inMagSnap)
    );
    lpm_accum #(.W(32)) uRemMag (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd), .addEn(symStrobe),
        .addVal({16'h0000, absFar}), .snap(remMagSnap)
    );
    lpm_accum #(.W(32)) uSlc (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd), .addEn(symStrobe),
        .addVal({16'h0000, absErr}), .snap(slcSnap)
    );
    lpm_accum #(.W(16)) uHiErr (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd),
        .addEn(symStrobe && absErr > noiseThreshold), .addVal(16'h0001),
        .snap(hiErrSnap)
    );
    lpm_accum #(.W(16)) uGood (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd),
        .addEn(symStrobe && goodBit), .addVal(16'h0001), .snap(goodSnap)
    );
    lpm_accum #(.W(16)) uInner (
        .clk(clk), .rst(rst), .intervalEnd(intervalEnd),
        .addEn(symStrobe && innerSym), .addVal(16'h0001), .snap(innerSnap)
    );

    // ---------------------------------------------------------------
    // bus decode and pair latching
    // ---------------------------------------------------------------
    // the high byte is latched when the low byte is read, so a snapshot
    // landing between the two reads cannot tear the pair
    logic [7:0] hiHold_r;
    logic [7:0] hiHold_nxt;
    logic [7:0] loopLow_r;
    logic [7:0] loopLow_nxt;
    logic [30:0] loop_r;
    logic [30:0] loop_nxt;
    logic [6:0] fetchIdx_r;
    logic [6:0] fetchIdx_nxt;
    logic [6:0] storeIdx_r;
    logic [6:0] storeIdx_nxt;
    logic [31:0] accData_r;
    logic [31:0] accData_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rdEn;
    logic wrEn;
    logic fetchReq;
    logic storeReq;
    logic fetchValid;
    logic [31:0] fetchData;
    logic [6:0] memIdx;
    logic [15:0] lowPick;
    logic isLow;

    always_comb begin
        rdEn = cs && rd;
        wrEn = cs && wr;
        fetchReq = wrEn && addr == lpm_pkg::FETCH_IDX;
        storeReq = wrEn && addr == lpm_pkg::STORE_IDX;
        memIdx = storeReq ? wdata[6:0] : fetchIdx_nxt;
        isLow = 1'b1;
        case (addr)
            lpm_pkg::DC_SUM_LO: lowPick = dcSnap[31:16];
            lpm_pkg::IN_MAG_LO: lowPick = inMagSnap[31:16];
            lpm_pkg::REM_MAG_LO: lowPick = remMagSnap[31:16];
            lpm_pkg::HI_ERR_LO: lowPick = hiErrSnap;
            lpm_pkg::GOOD_BIT_LO: lowPick = goodSnap;
            lpm_pkg::SLC_ERR_LO: lowPick = slcSnap[31:16];
            lpm_pkg::TLOOP_LO: lowPick = loop_r[30:15];
            default: begin
                lowPick = 16'h0000;
                isLow = 1'b0;
            end
        endcase
    end

    always_comb begin
        hiHold_nxt = hiHold_r;
        loopLow_nxt = loopLow_r;
        fetchIdx_nxt = fetchIdx_r;
        storeIdx_nxt = storeIdx_r;
        accData_nxt = accData_r;
        rdata_nxt = rdata_r;
        loop_nxt = loopStep ? loopNext : loop_r;
        if (rdEn) begin
            rdata_nxt = 8'h00;
            if (isLow) begin
                rdata_nxt = lowPick[7:0];
                hiHold_nxt = lowPick[15:8];
            end
            case (addr)
                lpm_pkg::DC_SUM_HI, lpm_pkg::IN_MAG_HI, lpm_pkg::REM_MAG_HI,
                lpm_pkg::HI_ERR_HI, lpm_pkg::GOOD_BIT_HI, lpm_pkg::SLC_ERR_HI,
                lpm_pkg::TLOOP_HI: rdata_nxt = hiHold_r;
                lpm_pkg::INNER_SYM: rdata_nxt = innerSnap[15:8];
                lpm_pkg::FETCH_IDX: rdata_nxt = {1'b0, fetchIdx_r};
                lpm_pkg::STORE_IDX: rdata_nxt = {1'b0, storeIdx_r};
                lpm_pkg::ACC_DATA0: rdata_nxt = accData_r[7:0];
                lpm_pkg::ACC_DATA1: rdata_nxt = accData_r[15:8];
                lpm_pkg::ACC_DATA2: rdata_nxt = accData_r[23:16];
                lpm_pkg::ACC_DATA3: rdata_nxt = accData_r[31:24];
                default: begin
                end
            endcase
        end
        if (wrEn) begin
            case (addr)
                lpm_pkg::TLOOP_LO: loopLow_nxt = wdata;
                lpm_pkg::TLOOP_HI: loop_nxt = {wdata, loopLow_r, loop_r[14:0]};
                lpm_pkg::FETCH_IDX: fetchIdx_nxt = wdata[6:0];
                lpm_pkg::STORE_IDX: storeIdx_nxt = wdata[6:0];
                lpm_pkg::ACC_DATA0: accData_nxt[7:0] = wdata;
                lpm_pkg::ACC_DATA1: accData_nxt[15:8] = wdata;
                lpm_pkg::ACC_DATA2: accData_nxt[23:16] = wdata;
                lpm_pkg::ACC_DATA3: accData_nxt[31:24] = wdata;
                default: begin
                end
            endcase
        end
        // the window is reloaded one cycle after a fetch write; a host that
        // touches the window meanwhile sees stale data
        if (fetchValid) begin
            accData_nxt = fetchData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hiHold_r <= 8'h00;
            loopLow_r <= 8'h00;
            loop_r <= lpm_pkg::LOOP_RST;
            fetchIdx_r <= lpm_pkg::IDX_RST;
            storeIdx_r <= lpm_pkg::IDX_RST;
            accData_r <= lpm_pkg::COEF_RST;
            rdata_r <= 8'h00;
        end else begin
            hiHold_r <= hiHold_nxt;
            loopLow_r <= loopLow_nxt;
            loop_r <= loop_nxt;
            fetchIdx_r <= fetchIdx_nxt;
            storeIdx_r <= storeIdx_nxt;
            accData_r <= accData_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // coefficient access
    // ---------------------------------------------------------------
    lpm_coef_mem uCoef (
        .clk(clk),
        .rst(rst),
        .fetchReq(fetchReq),
        .storeReq(storeReq),
        .idx(memIdx),
        .storeData(accData_r),
        .fetchValid(fetchValid),
        .fetchData(fetchData)
    );

    assign loopAcc = loop_r;
    assign rdata = rdata_r;
endmodule

// File: design/lpm_accum.sv
module lpm_accum #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic intervalEnd,
    input wire logic addEn,
    input wire logic [W-1:0] addVal,
    output logic [W-1:0] snap
);
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic [W-1:0] snap_r;
    logic [W-1:0] snap_nxt;
    logic [W-1:0] sum;

    always_comb begin
        sum = acc_r + (addEn ? addVal : '0);
        snap_nxt = snap_r;
        acc_nxt = sum;
        if (intervalEnd) begin
            snap_nxt = sum;
            acc_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= '0;
            snap_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            snap_r <= snap_nxt;
        end
    end

    assign snap = snap_r;
endmodule

// File: design/lpm_coef_mem.sv
module lpm_coef_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic fetchReq,
    input wire logic storeReq,
    input wire logic [6:0] idx,
    input wire logic [31:0] storeData,
    output logic fetchValid,
    output logic [31:0] fetchData
);
    // ---------------------------------------------------------------
    // coefficient store
    // ---------------------------------------------------------------
    logic [31:0] mem [lpm_pkg::COEF_NUM];
    logic [31:0] data_r;
    logic [31:0] data_nxt;
    logic valid_r;
    logic valid_nxt;
    logic inRange;

    always_comb begin
        inRange = idx <= lpm_pkg::IDX_MAX;
        valid_nxt = fetchReq;
        data_nxt = data_r;
        if (fetchReq && inRange) begin
            data_nxt = mem[idx];
        end else if (fetchReq) begin
            data_nxt = lpm_pkg::COEF_RST;
        end
    end

    // out-of-range index reads zero and never writes
    always_ff @(posedge clk) begin
        if (rst) begin
            data_r <= lpm_pkg::COEF_RST;
            valid_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            valid_r <= valid_nxt;
        end
        if (!rst && storeReq && inRange) begin
            mem[idx] <= storeData;
        end
    end

    assign fetchValid = valid_r;
    assign fetchData = data_r;
endmodule

// File: dv/lpm_checker_assertions.sv
module lpm_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic loopStep,
    input wire logic [30:0] loopNext,
    input wire logic [30:0] loopAcc
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic rdA = cs && rd && !wr;
    wire logic hiW = cs && wr && addr == 8'h5f;
    // only the low seven bits form the index, so bit 7 must not count here
    wire logic badF = cs && wr && addr == 8'h70 && wdata[6:0] > 7'h77;
    rd_hold_a: assert property (!(cs && rd) |=> $stable(rdata))
        else $error("rdata moved");
    rst_clear_a: assert property ($fell(rst) |-> rdata == 8'h00 && loopAcc == 31'h0)
        else $error("reset value");
    loop_lo_a: assert property (rdA && addr == 8'h5e |=> rdata == $past(loopAcc[22:15]))
        else $error("loop low byte");
    loop_pair_a: assert property (rdA && addr == 8'h5e ##1 rdA && addr == 8'h5f
        |=> rdata == $past(loopAcc[30:23], 2))
        else $error("loop high byte");
    step_load_a: assert property (loopStep && !hiW |=> loopAcc == $past(loopNext))
        else $error("loop step");
    loop_keep_a: assert property (!loopStep && !hiW |=> $stable(loopAcc))
        else $error("loop moved");
    hi_write_a: assert property (hiW |=> loopAcc[30:23] == $past(wdata))
        else $error("loop write");
    bad_fetch_a: assert property (badF ##3 rdA && addr == 8'h7c |=> rdata == 8'h00)
        else $error("bad fetch");
    cover property (hiW);
    cover property (badF);
    cover property (rdA && addr == 8'h44);
endmodule

bind line_perf_meters_and_coef_access lpm_checker chk (.clk(clk), .rst(rst), .cs(cs),
    .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .loopStep(loopStep),
    .loopNext(loopNext), .loopAcc(loopAcc));

// File: dv/lpm_host.sv
module lpm_host (
    input wire logic clk,
    output logic cs,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cs, wr, rd, addr, wdata} = 19'h0;
    // strobes stay up between cycles so none toggles twice in one step
    // callers read pairs low byte first and write the loop low byte first
    task automatic busWr(input logic [7:0] a, input logic [7:0] d);
        {cs, wr, rd, addr, wdata} = {3'h6, a, d};
        @(posedge clk);
        #1;
    endtask
    task automatic busRd(input logic [7:0] a, output logic [7:0] d);
        {cs, wr, rd, addr} = {3'h5, a};
        @(posedge clk);
        #1;
        d = rdata;
    endtask
    // released lines show the inverse; a fetch is followed only by idle and the window
    task automatic busIdle(input int n);
        {cs, wr, rd, addr, wdata} = {3'h0, ~addr, ~wdata};
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, symStrobe, intervalEnd, descramblerMode, detBit, scrBit, loopStep;
    logic [15:0] rxInput, rxFarEnd, slicerErr, noiseThreshold;
    logic [1:0] symbolCode;
    logic [30:0] loopNext, loopAcc;
    logic cs, wr, rd;
    logic [7:0] addr, wdata, rdata, rb;
    int errors = 0;
    int n_checks = 0;
    line_perf_meters_and_coef_access DUT (.*);
    lpm_host host (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] mag(input logic [15:0] x);
        return {16'h0, x[15] ? -x : x};
    endfunction
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        host.busRd(a, rb);
        check(32'(rb), 32'(e));
    endtask
    task automatic pair(input logic [7:0] a, input logic [15:0] e);
        rdChk(a, e[7:0]);
        rdChk(a + 8'h01, e[15:8]);
    endtask
    task automatic win(input logic [31:0] e);
        for (int k = 0; k < 4; k++)
            rdChk(8'h7c + 8'(k), e[8*k+:8]);
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic meters(input logic mode);
        logic [31:0] dc, sl, fe, nl;
        logic [15:0] ne, gb, sy, v;
        logic [30:0] lp;
        {dc, sl, fe, nl, ne, gb, sy} = '0;
        lp = loopAcc;
        noiseThreshold = mode ? 16'h7e00 : 16'h7f00;
        for (int i = 0; i < 700; i++) begin
            v = i[0] ? 16'h8000 + 16'(i) : 16'h7f00 - 16'(i);
            {rxInput, rxFarEnd, slicerErr} = {v, v ^ 16'h0ff0, v + 16'h0080};
            {symbolCode, detBit, scrBit, descramblerMode} = {i[1:0], i[0], i[2], mode};
            {symStrobe, intervalEnd} = {i % 5 != 4, i == 699};
            {loopStep, loopNext} = {i[3], 16'(i), 15'(i)};
            if (loopStep)
                lp = loopNext;
            if (symStrobe) begin
                dc += {{16{v[15]}}, v};
                sl += mag(v);
                fe += mag(rxFarEnd);
                nl += mag(slicerErr);
                ne += 16'(mag(slicerErr) > {16'h0, noiseThreshold});
                gb += 16'(mode ? scrBit : detBit == scrBit);
                sy += 16'(^symbolCode);
            end
            @(posedge clk);
            #1;
        end
        {symStrobe, intervalEnd, loopStep} = 3'h0;
        check(32'(loopAcc), 32'(lp));
        pair(8'h44, dc[31:16]);
        pair(8'h46, sl[31:16]);
        pair(8'h48, fe[31:16]);
        pair(8'h4a, ne);
        pair(8'h4c, gb);
        pair(8'h50, nl[31:16]);
        rdChk(8'h4e, sy[15:8]);
        host.busIdle(1);
    endtask
    task automatic loopRw;
        logic [30:0] e;
        e = 31'h5a5ac3c3;
        {loopNext, loopStep} = {e, 1'b1};
        @(posedge clk);
        #1;
        loopStep = 1'b0;
        pair(8'h5e, e[30:15]);
        host.busWr(8'h5e, 8'h3c);
        host.busRd(8'h44, rb);
        host.busWr(8'h5f, 8'h81);
        host.busIdle(1);
        e[30:15] = 16'h813c;
        check(32'(loopAcc), 32'(e));
        pair(8'h5e, 16'h813c);
        host.busIdle(1);
    endtask
    task automatic coefRw;
        for (int k = 0; k < 4; k++)
            host.busWr(8'h7c + 8'(k), 8'(32'hdeadbeef >> 8 * k));
        host.busWr(8'h71, 8'h77);
        host.busIdle(2);
        win(32'hdeadbeef);
        for (int k = 0; k < 4; k++)
            host.busWr(8'h7c + 8'(k), 8'h00);
        host.busWr(8'h70, 8'h77);
        host.busIdle(2);
        win(32'hdeadbeef);
        host.busWr(8'h70, 8'h78);
        host.busIdle(2);
        win(32'h0);
        rdChk(8'h71, 8'h77);
        host.busIdle(1);
    endtask
    // a second reset in mid-run must bring the loop, DC sum, fetch index and window back to zero
    task automatic midReset;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        pair(8'h5e, 16'h0000);
        pair(8'h44, 16'h0000);
        rdChk(8'h70, 8'h00);
        win(32'h0);
        host.busIdle(1);
    endtask
    initial begin
        {rst, symStrobe, intervalEnd, descramblerMode, detBit, scrBit, loopStep} = 7'h40;
        {rxInput, rxFarEnd, slicerErr, symbolCode, loopNext} = '0;
        noiseThreshold = 16'h7f00;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        meters(1'b0);
        meters(1'b1);
        loopRw();
        coefRw();
        midReset();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule

// File: include/lpm_pkg.sv
package lpm_pkg;
    // -----------------------------------------------------------------
    // register byte addresses
    // -----------------------------------------------------------------
    localparam logic [7:0] METER_LO = 8'h40;
    localparam logic [7:0] METER_HI = 8'h5f;
    localparam logic [7:0] DC_SUM_LO = 8'h44;
    localparam logic [7:0] DC_SUM_HI = 8'h45;
    localparam logic [7:0] IN_MAG_LO = 8'h46;
    localparam logic [7:0] IN_MAG_HI = 8'h47;
    localparam logic [7:0] REM_MAG_LO = 8'h48;
    localparam logic [7:0] REM_MAG_HI = 8'h49;
    localparam logic [7:0] HI_ERR_LO = 8'h4a;
    localparam logic [7:0] HI_ERR_HI = 8'h4b;
    localparam logic [7:0] GOOD_BIT_LO = 8'h4c;
    localparam logic [7:0] GOOD_BIT_HI = 8'h4d;
    localparam logic [7:0] INNER_SYM = 8'h4e;
    localparam logic [7:0] SLC_ERR_LO = 8'h50;
    localparam logic [7:0] SLC_ERR_HI = 8'h51;
    localparam logic [7:0] TLOOP_LO = 8'h5e;
    localparam logic [7:0] TLOOP_HI = 8'h5f;
    localparam logic [7:0] FETCH_IDX = 8'h70;
    localparam logic [7:0] STORE_IDX = 8'h71;
    localparam logic [7:0] ACC_DATA0 = 8'h7c;
    localparam logic [7:0] ACC_DATA1 = 8'h7d;
    localparam logic [7:0] ACC_DATA2 = 8'h7e;
    localparam logic [7:0] ACC_DATA3 = 8'h7f;

    // -----------------------------------------------------------------
    // sizes and reset values
    // -----------------------------------------------------------------
    localparam int COEF_NUM = 120;
    localparam int SUM_W = 32;
    localparam int CNT_W = 16;
    localparam int LOOP_W = 31;
    localparam logic [30:0] LOOP_RST = 31'h00000000;
    localparam logic [6:0] IDX_RST = 7'h00;
    localparam logic [31:0] COEF_RST = 32'h00000000;
    localparam logic [6:0] IDX_MAX = 7'h77;
endpackage
